// [design/rnj_node.sv]
`timescale 1ns/10ps

module rnj_node #(
   parameter int RETRY_CYCLES = rnj_pkg::RETRY_CYC,
   parameter int LISTEN_CYCLES = rnj_pkg::LISTEN_CYC,
   parameter logic [7:0] SLOW_RATE_MAX = 8'd100
) (
   input wire logic CORE_CLK_I,
   input wire logic ARST_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire rnj_pkg::rnj_ring_in_t RING_I,
   output rnj_pkg::rnj_ring_out_t RING_O,
   output logic GREEN_TX_LED_O,
   output logic YELLOW_HOST_LED_O,
   output logic ONLINE_LED_O,
   output logic IRQ_O
);
   import rnj_pkg::*;

   typedef enum logic [2:0] {
      ST_CHECK, ST_LISTEN, ST_BURST, ST_ONLINE, ST_MISMATCH, ST_HALT
   } rnj_state_t;

   // ----------------------------------------------------------------
   // Input synchronisers and edge detection.
   // ----------------------------------------------------------------
   rnj_ring_in_t sync1_ff, sync2_ff, prev_ff, rise;

   // Two stages before use; only stage two feeds logic.
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         prev_ff <= '0;
      end else begin
         sync1_ff <= RING_I;
         sync2_ff <= sync1_ff;
         prev_ff <= sync2_ff;
      end
   end

   // Ring events arrive as pulses; count each rising edge once.
   assign rise = sync2_ff & ~prev_ff;

   // ----------------------------------------------------------------
   // APB slave.
   // ----------------------------------------------------------------
   logic acc, wr, rd;
   logic [31:0] cfg_ff;
   logic [3:0] diag_sel_ff;
   logic [IRQ_W-1:0] irq_stat_ff, irq_en_ff, irq_set;
   logic reinit, nc_send;

   // Zero-wait slave: every access completes in its first access cycle.
   assign PREADY_O = 1'b1;
   assign acc = PSEL_I & PENABLE_I;
   assign wr = acc & PWRITE_I;
   assign rd = acc & ~PWRITE_I;
   assign reinit = wr && PADDR_I == ADDR_CTRL && PWDATA_I[CTRL_REINIT_BIT];
   assign nc_send = wr && PADDR_I == ADDR_CTRL && PWDATA_I[CTRL_NC_SEND_BIT];

   function automatic logic mapped(input logic [7:0] a);
      return a == ADDR_CTRL || a == ADDR_CFG || a == ADDR_STATUS ||
             a == ADDR_DIAG_SEL || a == ADDR_DIAG_DATA ||
             a == ADDR_IRQ_STATUS || a == ADDR_IRQ_CLEAR ||
             a == ADDR_IRQ_ENABLE;
   endfunction : mapped

   // Unmapped addresses are flagged with an error response.
   assign PSLVERR_O = acc & ~mapped(PADDR_I);

   // Configuration and diagnostic selector registers.
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         cfg_ff <= CFG_RST;
         diag_sel_ff <= 4'h0;
         irq_en_ff <= '0;
      end else begin
         if (wr && PADDR_I == ADDR_CFG) cfg_ff <= PWDATA_I;
         if (wr && PADDR_I == ADDR_DIAG_SEL) diag_sel_ff <= PWDATA_I[3:0];
         if (wr && PADDR_I == ADDR_IRQ_ENABLE) irq_en_ff <= PWDATA_I[IRQ_W-1:0];
      end
   end

   logic [11:0] cfg_addr;
   logic [3:0] cfg_rate;
   logic [7:0] cfg_slow;
   assign cfg_addr = cfg_ff[CFG_ADDR_LSB +: 12];
   assign cfg_rate = cfg_ff[CFG_RATE_LSB +: 4];
   assign cfg_slow = cfg_ff[CFG_SLOW_LSB +: 8];

   // ----------------------------------------------------------------
   // Join state machine.
   // ----------------------------------------------------------------
   rnj_state_t state_ff;
   logic [7:0] trip_ff;
   logic [23:0] timer_ff;
   logic act_seen_ff, tok_seen_ff, dup_seen_ff;
   logic burst_done;
   logic burst_start;
   logic [3:0] sym_ff;
   logic [9:0] rep_ff;
   logic burst_on_ff;
   logic [7:0] nxt_trip;

   // First error wins; later checks never overwrite a standing code.
   always_comb begin
      nxt_trip = trip_ff;
      if (trip_ff == TRIP_NONE && state_ff == ST_CHECK) begin
         if (sync2_ff.hw_fail) nxt_trip = TRIP_HW;
         else if (cfg_addr > ADDR_MAX || cfg_rate > RATE_MAX)
            nxt_trip = TRIP_CFG;
         else if (cfg_slow > SLOW_RATE_MAX) nxt_trip = TRIP_CYC;
      end else if (trip_ff == TRIP_NONE && state_ff == ST_LISTEN &&
                   timer_ff == 24'(LISTEN_CYCLES - 1)) begin
         if (dup_seen_ff || sync2_ff.dup_addr) nxt_trip = TRIP_DUP;
         else if (act_seen_ff && !tok_seen_ff)
            nxt_trip = TRIP_RATE;
      end
   end

   // Trip code only clears on reset, so the host can read it late.
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) trip_ff <= TRIP_NONE;
      else trip_ff <= nxt_trip;
   end

   // Sequencer; starts its check straight after reset release.
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         state_ff <= ST_CHECK;
         timer_ff <= '0;
         act_seen_ff <= 1'b0;
         tok_seen_ff <= 1'b0;
         dup_seen_ff <= 1'b0;
      end else begin
         unique case (state_ff)
            ST_CHECK: begin
               timer_ff <= '0;
               act_seen_ff <= 1'b0;
               tok_seen_ff <= 1'b0;
               dup_seen_ff <= 1'b0;
               if (nxt_trip != TRIP_NONE) state_ff <= ST_HALT;
               else state_ff <= ST_LISTEN;
            end
            ST_LISTEN: begin
               // Receive only: nothing is driven onto the ring here.
               act_seen_ff <= act_seen_ff | sync2_ff.activity;
               tok_seen_ff <= tok_seen_ff | rise.token;
               dup_seen_ff <= dup_seen_ff | sync2_ff.dup_addr;
               timer_ff <= timer_ff + 24'd1;
               if (timer_ff == 24'(LISTEN_CYCLES - 1)) begin
                  timer_ff <= '0;
                  if (nxt_trip == TRIP_RATE) state_ff <= ST_MISMATCH;
                  else if (nxt_trip != TRIP_NONE) state_ff <= ST_HALT;
                  else state_ff <= ST_BURST;
               end
            end
            ST_BURST: begin
               // A standing rate trip keeps the node retrying off-line.
               if (burst_done && trip_ff != TRIP_NONE)
                  state_ff <= ST_MISMATCH;
               else if (burst_done) state_ff <= ST_ONLINE;
            end
            ST_ONLINE: begin
               if (reinit) state_ff <= ST_CHECK;
            end
            ST_MISMATCH: begin
               timer_ff <= timer_ff + 24'd1;
               if (timer_ff == 24'(RETRY_CYCLES - 1)) begin
                  timer_ff <= '0;
                  state_ff <= ST_BURST;
               end
            end
            ST_HALT: begin
               if (reinit) state_ff <= ST_CHECK;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Reconfiguration burst generator.
   // ----------------------------------------------------------------
   // One symbol per clock: eight marks then a space, 765 rounds.
   assign burst_start = state_ff != ST_BURST && !burst_on_ff &&
      ((state_ff == ST_LISTEN && timer_ff == 24'(LISTEN_CYCLES - 1) &&
        nxt_trip == TRIP_NONE) ||
       (state_ff == ST_MISMATCH && timer_ff == 24'(RETRY_CYCLES - 1)));
   assign burst_done = burst_on_ff && sym_ff == 4'(BURST_PULSES) &&
      rep_ff == 10'(BURST_REPEATS - 1);

   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         burst_on_ff <= 1'b0;
         sym_ff <= '0;
         rep_ff <= '0;
      end else if (burst_start) begin
         burst_on_ff <= 1'b1;
         sym_ff <= '0;
         rep_ff <= '0;
      end else if (burst_on_ff) begin
         if (sym_ff == 4'(BURST_PULSES)) begin
            sym_ff <= '0;
            rep_ff <= rep_ff + 10'd1;
            if (burst_done) burst_on_ff <= 1'b0;
         end else begin
            sym_ff <= sym_ff + 4'd1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Non-cyclic message retry engine.
   // ----------------------------------------------------------------
   logic nc_busy_ff, nc_tx_ff;
   logic [2:0] nc_try_ff;
   logic nc_abandon, nc_fail;

   assign nc_fail = nc_busy_ff & rise.nc_noresp;
   assign nc_abandon = nc_fail && nc_try_ff == 3'(NC_ATTEMPTS);

   // Each failure re-sends until the fifth attempt has failed too.
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         nc_busy_ff <= 1'b0;
         nc_tx_ff <= 1'b0;
         nc_try_ff <= '0;
      end else begin
         nc_tx_ff <= 1'b0;
         if (!nc_busy_ff && nc_send && state_ff == ST_ONLINE) begin
            nc_busy_ff <= 1'b1;
            nc_tx_ff <= 1'b1;
            nc_try_ff <= 3'd1;
         end else if (nc_busy_ff && rise.nc_ack) begin
            nc_busy_ff <= 1'b0;
         end else if (nc_abandon) begin
            nc_busy_ff <= 1'b0;
         end else if (nc_fail) begin
            nc_tx_ff <= 1'b1;
            nc_try_ff <= nc_try_ff + 3'd1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Diagnostic counters.
   // ----------------------------------------------------------------
   logic [31:0] message_count;
   logic [15:0] cnt_ff [2:9];
   logic [8:0] cnt_inc;

   // Index map follows the readout function's argument numbers.
   assign cnt_inc[2] = rise.overrun;
   assign cnt_inc[3] = rise.lost;
   assign cnt_inc[4] = nc_fail;
   assign cnt_inc[5] = rise.recon_seen;
   assign cnt_inc[6] = rise.excess_nack;
   assign cnt_inc[7] = rise.dup_sync;
   assign cnt_inc[8] = burst_start;
   assign cnt_inc[1:0] = 2'b00;

   // Counting is passive; no counter feeds back into the sequencer.
   generate
      for (genvar i = 2; i <= 9; i++) begin : g_cnt
         logic inc;
         if (i == 9) begin : g_nc
            assign inc = rise.noncyclic;
         end else begin : g_ev
            assign inc = cnt_inc[i];
         end
         always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
            if (!ARST_N_I) cnt_ff[i] <= '0;
            else if (inc) cnt_ff[i] <= cnt_ff[i] + 16'd1;
         end
      end
   endgenerate

   // Both directions may land in one cycle; each counts as one.
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) message_count <= '0;
      else message_count <= message_count + 32'(rise.msg_tx) +
                            32'(rise.msg_rx);
   end

   function automatic logic [31:0] diag_value(input logic [3:0] sel);
      if (sel == 4'd1) return message_count;
      if (sel >= 4'd2 && sel <= 4'd9) return {16'h0000, cnt_ff[sel]};
      if (sel == DIAG_LOST_ROUTE) return 32'h0000_0000;
      return 32'h0000_0000;
   endfunction : diag_value

   // ----------------------------------------------------------------
   // Interrupts.
   // ----------------------------------------------------------------
   logic online_prev_ff;
   assign irq_set[IRQ_TRIP_BIT] = trip_ff == TRIP_NONE && nxt_trip != TRIP_NONE;
   assign irq_set[IRQ_ONLINE_BIT] = state_ff == ST_ONLINE && !online_prev_ff;
   assign irq_set[IRQ_ABANDON_BIT] = nc_abandon;
   assign irq_set[IRQ_RETRY_BIT] = burst_start && state_ff == ST_MISMATCH;

   // A set in the same cycle as its clear wins.
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         irq_stat_ff <= '0;
         online_prev_ff <= 1'b0;
      end else begin
         online_prev_ff <= state_ff == ST_ONLINE;
         if (wr && PADDR_I == ADDR_IRQ_CLEAR)
            irq_stat_ff <= (irq_stat_ff & ~PWDATA_I[IRQ_W-1:0]) | irq_set;
         else
            irq_stat_ff <= irq_stat_ff | irq_set;
      end
   end

   // ----------------------------------------------------------------
   // Outputs: read data, ring drive, lamps.
   // ----------------------------------------------------------------
   logic [31:0] nxt_rdata;

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      unique case (PADDR_I)
         ADDR_CFG: nxt_rdata = cfg_ff;
         ADDR_STATUS: begin
            nxt_rdata[STAT_TRIP_LSB +: 8] = trip_ff;
            nxt_rdata[STAT_ONLINE_BIT] = state_ff == ST_ONLINE;
            nxt_rdata[STAT_NC_BUSY_BIT] = nc_busy_ff;
         end
         ADDR_DIAG_SEL: nxt_rdata = {28'h000_0000, diag_sel_ff};
         ADDR_DIAG_DATA: nxt_rdata = diag_value(diag_sel_ff);
         ADDR_IRQ_STATUS: nxt_rdata[IRQ_W-1:0] = irq_stat_ff;
         ADDR_IRQ_ENABLE: nxt_rdata[IRQ_W-1:0] = irq_en_ff;
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   // Read data is registered in the setup cycle, so it is valid in access.
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) PRDATA_O <= '0;
      else if (PSEL_I && !PENABLE_I && !PWRITE_I) PRDATA_O <= nxt_rdata;
   end

   // Lamps and ring drive are all registered to stay glitch free.
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         RING_O <= '0;
         GREEN_TX_LED_O <= 1'b0;
         YELLOW_HOST_LED_O <= 1'b0;
         ONLINE_LED_O <= 1'b0;
         IRQ_O <= 1'b0;
      end else begin
         RING_O.online <= state_ff == ST_ONLINE;
         RING_O.recon_tx <= burst_on_ff &&
                            sym_ff != 4'(BURST_PULSES);
         RING_O.nc_tx <= nc_tx_ff;
         GREEN_TX_LED_O <= sync2_ff.tx_busy;
         YELLOW_HOST_LED_O <= PSEL_I;
         ONLINE_LED_O <= state_ff == ST_ONLINE;
         IRQ_O <= |(irq_stat_ff & irq_en_ff);
      end
   end

   logic unused;
   assign unused = rd | (|sync2_ff.msg_tx) | rise.hw_fail;

endmodule : rnj_node

// [design/rnj_pkg.sv]
package rnj_pkg;

   // ----------------------------------------------------------------
   // Register map, byte addresses on a 32-bit APB.
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CFG = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_DIAG_SEL = 8'h0C;
   localparam logic [7:0] ADDR_DIAG_DATA = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h18;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1C;

   // ----------------------------------------------------------------
   // Field positions.
   // ----------------------------------------------------------------
   localparam int CTRL_REINIT_BIT = 0;
   localparam int CTRL_NC_SEND_BIT = 1;
   localparam int CFG_ADDR_LSB = 0;
   localparam int CFG_RATE_LSB = 12;
   localparam int CFG_SLOW_LSB = 16;
   localparam int STAT_TRIP_LSB = 0;
   localparam int STAT_ONLINE_BIT = 8;
   localparam int STAT_NC_BUSY_BIT = 9;
   localparam int IRQ_TRIP_BIT = 0;
   localparam int IRQ_ONLINE_BIT = 1;
   localparam int IRQ_ABANDON_BIT = 2;
   localparam int IRQ_RETRY_BIT = 3;
   localparam int IRQ_W = 4;

   // ----------------------------------------------------------------
   // Reset values and limits.
   // ----------------------------------------------------------------
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam logic [11:0] ADDR_MAX = 12'h0FF;
   localparam logic [3:0] RATE_MAX = 4'h2;
   localparam logic [7:0] TRIP_NONE = 8'h00;
   localparam logic [7:0] TRIP_HW = 8'd60;
   localparam logic [7:0] TRIP_CFG = 8'd61;
   localparam logic [7:0] TRIP_RATE = 8'd62;
   localparam logic [7:0] TRIP_DUP = 8'd63;
   localparam logic [7:0] TRIP_CYC = 8'd64;
   localparam logic [3:0] DIAG_LOST_ROUTE = 4'd10;

   // ----------------------------------------------------------------
   // Timing.
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int RETRY_PERIOD_MS = 1000;
   localparam int RETRY_CYC = RETRY_PERIOD_MS * (1000000 / CLK_PERIOD_NS);
   localparam int LISTEN_US = 1000;
   localparam int LISTEN_CYC = LISTEN_US * 1000 / CLK_PERIOD_NS;
   localparam int BURST_PULSES = 8;
   localparam int BURST_REPEATS = 765;
   localparam int NC_ATTEMPTS = 5;

   // ----------------------------------------------------------------
   // Ring-side inputs, all asynchronous to the node clock.
   // ----------------------------------------------------------------
   typedef struct packed {
      logic hw_fail;
      logic activity;
      logic token;
      logic dup_addr;
      logic tx_busy;
      logic msg_tx;
      logic msg_rx;
      logic overrun;
      logic lost;
      logic recon_seen;
      logic excess_nack;
      logic dup_sync;
      logic noncyclic;
      logic nc_ack;
      logic nc_noresp;
   } rnj_ring_in_t;

   typedef struct packed {
      logic online;
      logic recon_tx;
      logic nc_tx;
   } rnj_ring_out_t;

endpackage : rnj_pkg

// [testbench/rnj_node_assertions.sv]
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Port-level checks on the ring node.
// ----------------------------------------------------------------
module rnj_node_assertions
   import rnj_pkg::*;
(
   input wire logic CORE_CLK_I,
   input wire logic ARST_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire rnj_pkg::rnj_ring_in_t RING_I,
   input wire rnj_pkg::rnj_ring_out_t RING_O,
   input wire logic GREEN_TX_LED_O,
   input wire logic YELLOW_HOST_LED_O,
   input wire logic ONLINE_LED_O
);
   // All checks share the node clock and sleep while reset is held.
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!ARST_N_I);

   // Host write to the control word, the only way off the ring.
   logic ctrl_wr;
   assign ctrl_wr = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == ADDR_CTRL;

   property p_yellow; YELLOW_HOST_LED_O == $past(PSEL_I); endproperty
   a_yellow: assert property (p_yellow) else $error("host lamp off");
   property p_green_on; $rose(GREEN_TX_LED_O) |-> $past(RING_I.tx_busy, 3);
   endproperty
   a_green_on: assert property (p_green_on) else $error("tx lamp");
   property p_green_off;
      $fell(GREEN_TX_LED_O) |-> !$past(RING_I.tx_busy, 3);
   endproperty
   a_green_off: assert property (p_green_off) else $error("tx lamp");
   property p_led; ONLINE_LED_O == RING_O.online; endproperty
   a_led: assert property (p_led) else $error("online lamp");
   property p_nc_online; RING_O.nc_tx |-> RING_O.online; endproperty
   a_nc_online: assert property (p_nc_online) else $error("send off");
   property p_nc_pulse; RING_O.nc_tx |=> !RING_O.nc_tx; endproperty
   a_nc_pulse: assert property (p_nc_pulse) else $error("long send");
   // Burst shape: eight marks then a single space.
   property p_burst;
      $rose(RING_O.recon_tx) |-> RING_O.recon_tx[*8] ##1 !RING_O.recon_tx;
   endproperty
   a_burst: assert property (p_burst) else $error("burst shape");
   property p_burst_off; RING_O.recon_tx |-> !RING_O.online; endproperty
   a_burst_off: assert property (p_burst_off) else $error("burst on");
   // Only a host reinit may take the node off the ring.
   // The on-line output lags the state by one cycle, hence the past term.
   property p_stay;
      RING_O.online && !ctrl_wr && !$past(ctrl_wr) |=> RING_O.online;
   endproperty
   a_stay: assert property (p_stay) else $error("dropped off");
endmodule : rnj_node_assertions

bind rnj_node rnj_node_assertions rnj_node_assertions_i (
   .CORE_CLK_I(CORE_CLK_I), .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I),
   .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
   .RING_I(RING_I), .RING_O(RING_O), .GREEN_TX_LED_O(GREEN_TX_LED_O),
   .YELLOW_HOST_LED_O(YELLOW_HOST_LED_O), .ONLINE_LED_O(ONLINE_LED_O)
);

// [testbench/rnj_ring_peer.sv]
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Other nodes on the ring, as this node's pins see them.
// ----------------------------------------------------------------
module rnj_ring_peer
   import rnj_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire rnj_pkg::rnj_ring_out_t ring_out_i,
   input wire logic hw_fail_i,
   input wire logic run_i,
   input wire logic token_i,
   input wire logic dup_i,
   input wire logic ack_i,
   output rnj_pkg::rnj_ring_in_t ring_in_o
);
   logic [3:0] tick_ff;
   logic [2:0] busy_ff;
   logic [2:0] dly_ff;
   logic tok;

   // Transmitter stays busy six cycles; the target replies after four.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_ff <= 4'h0;
         busy_ff <= 3'h0;
         dly_ff <= 3'h0;
      end else begin
         tick_ff <= tick_ff + 4'h1;
         busy_ff <= ring_out_i.nc_tx ? 3'h6 : busy_ff - 3'(busy_ff != 3'h0);
         dly_ff <= ring_out_i.nc_tx ? 3'h4 : dly_ff - 3'(dly_ff != 3'h0);
      end
   end

   // Token, traffic and protocol faults come round every sixteen cycles.
   assign tok = token_i && (tick_ff == 4'h0);
   always_comb begin
      ring_in_o = '0;
      ring_in_o.hw_fail = hw_fail_i;
      ring_in_o.activity = run_i;
      ring_in_o.token = tok;
      ring_in_o.dup_addr = dup_i;
      ring_in_o.tx_busy = busy_ff != 3'h0;
      ring_in_o.msg_rx = tok;
      ring_in_o.overrun = tok;
      ring_in_o.lost = tok;
      ring_in_o.nc_ack = ack_i && dly_ff == 3'h1;
      ring_in_o.nc_noresp = !ack_i && dly_ff == 3'h1;
   end
endmodule : rnj_ring_peer

// [testbench/tb.sv]
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Self-checking bench for the ring node.
// ----------------------------------------------------------------
module tb;
   import rnj_pkg::*;

   logic clk = 1'h0;
   logic arst_n, psel, penable, pwrite, serr, recon_q;
   logic hw, run, tok, dup, ack;
   logic [7:0] paddr;
   logic [31:0] pwdata, rdat, prdata;
   logic pready, pslverr, green, yellow, online_led, irq;
   int errors, total_checks, bursts, sends;
   rnj_ring_in_t ring_in;
   rnj_ring_out_t ring_out;

   always #50 clk = ~clk;

   rnj_node #(.RETRY_CYCLES(50), .LISTEN_CYCLES(20),
      .SLOW_RATE_MAX(8'h64)) rnj_node_i (
      .CORE_CLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .RING_I(ring_in), .RING_O(ring_out),
      .GREEN_TX_LED_O(green), .YELLOW_HOST_LED_O(yellow),
      .ONLINE_LED_O(online_led), .IRQ_O(irq));

   rnj_ring_peer rnj_ring_peer_i (.clk_i(clk), .rst_n_i(arst_n),
      .ring_out_i(ring_out), .hw_fail_i(hw), .run_i(run), .token_i(tok),
      .dup_i(dup), .ack_i(ack), .ring_in_o(ring_in));

   // Counts burst rounds (each rising edge of recon_tx) and send attempts seen on the ring.
   always @(posedge clk) begin
      recon_q <= ring_out.recon_tx;
      if (ring_out.recon_tx && !recon_q) bursts++;
      if (ring_out.nc_tx) sends++;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check

   // One bus transfer; the request holds until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      rdat = prdata;
      serr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      apb(1'h0, a, 32'h0000_0000);
   endtask : rd

   task automatic rst();
      {hw, run, tok, dup, ack} <= 5'h00;
      arst_n <= 1'h0;
      repeat (4) @(posedge clk);
      arst_n <= 1'h1;
      bursts = 0;
      @(posedge clk);
   endtask : rst

   // Bounded wait for the node to enter the ring.
   task automatic wait_on();
      for (int i = 0; i < 9000 && ring_out.online !== 1'h1; i++)
         @(posedge clk);
   endtask : wait_on

   task automatic t_join();
      rst();
      wait_on();
      rd(ADDR_STATUS);
      check(rdat, 32'h0000_0100);
      check({31'h0, online_led}, 32'h0000_0001);
      check(32'(bursts), 32'h0000_02FD);
      wr(ADDR_DIAG_SEL, 32'h0000_0008);
      rd(ADDR_DIAG_DATA);
      check(rdat, 32'h0000_0001);
      wr(ADDR_DIAG_SEL, 32'h0000_000A);
      rd(ADDR_DIAG_DATA);
      check(rdat, 32'h0000_0000);
      rd(8'h40);
      check({serr, rdat[30:0]}, 32'h8000_0000);
      $display("join test done");
   endtask : t_join

   // Unanswered message: five attempts, abandon, the node stays up.
   task automatic t_nc();
      run <= 1'h1;
      tok <= 1'h1;
      wr(ADDR_IRQ_ENABLE, 32'h0000_0004);
      sends = 0;
      wr(ADDR_CTRL, 32'h0000_0002);
      for (int i = 0; i < 300 && irq !== 1'h1; i++) @(posedge clk);
      check(32'(sends), 32'h0000_0005);
      rd(ADDR_IRQ_STATUS);
      check(rdat, 32'h0000_0006);
      wr(ADDR_DIAG_SEL, 32'h0000_0004);
      rd(ADDR_DIAG_DATA);
      check(rdat, 32'h0000_0005);
      rd(ADDR_STATUS);
      check(rdat, 32'h0000_0100);
      wr(ADDR_IRQ_CLEAR, 32'h0000_0004);
      repeat (3) @(posedge clk);
      check({31'h0, irq}, 32'h0000_0000);
      ack <= 1'h1;
      sends = 0;
      wr(ADDR_CTRL, 32'h0000_0002);
      repeat (20) @(posedge clk);
      check(32'(sends), 32'h0000_0001);
      $display("send test done");
   endtask : t_nc

   // Join, then reinit into a fault; a later fault must not replace it.
   task automatic t_trip(input logic [31:0] cfg, input logic h, a, d,
      input logic [7:0] exp);
      rst();
      wait_on();
      hw <= h;
      run <= a;
      dup <= d;
      wr(ADDR_IRQ_ENABLE, 32'h0000_0001);
      wr(ADDR_CFG, cfg);
      wr(ADDR_CTRL, 32'h0000_0001);
      repeat (40) @(posedge clk);
      rd(ADDR_STATUS);
      check(rdat, {24'h00_0000, exp});
      check({31'h0, irq}, 32'h0000_0001);
      check({31'h0, online_led}, 32'h0000_0000);
      wr(ADDR_CFG, 32'h0065_0000);
      wr(ADDR_CTRL, 32'h0000_0001);
      repeat (40) @(posedge clk);
      rd(ADDR_STATUS);
      check(rdat, {24'h00_0000, exp});
      $display("trip test done");
   endtask : t_trip

   // Mismatch keeps bursting; a reset on a quiet ring rejoins.
   task automatic t_mismatch();
      t_trip(32'h0000_0000, 1'h0, 1'h1, 1'h0, TRIP_RATE);
      repeat (16000) @(posedge clk);
      check(32'(bursts >= 3), 32'h0000_0001);
      rd(ADDR_IRQ_STATUS);
      check(rdat, 32'h0000_000B);
      rd(ADDR_STATUS);
      check(rdat, 32'h0000_003E);
      rst();
      wait_on();
      check({31'h0, ring_out.online}, 32'h0000_0001);
      $display("mismatch test done");
   endtask : t_mismatch

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results

   // Main sequence; every input has a value at time zero.
   initial begin
      {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      {hw, run, tok, dup, ack, recon_q} = 6'h00;
      t_join();
      t_nc();
      t_trip(32'h0000_0000, 1'h1, 1'h0, 1'h0, TRIP_HW);
      t_trip(32'h0000_0100, 1'h0, 1'h0, 1'h0, TRIP_CFG);
      t_trip(32'h0000_3000, 1'h0, 1'h0, 1'h0, TRIP_CFG);
      t_trip(32'h0065_0000, 1'h0, 1'h0, 1'h0, TRIP_CYC);
      t_trip(32'h0000_0000, 1'h0, 1'h0, 1'h1, TRIP_DUP);
      t_mismatch();
      results();
   end

   // Hang guard, set well past the expected run length.
   initial begin
      #9_000_000;
      errors++;
      results();
   end
endmodule : tb
